// ===== sems_pkg.sv
`default_nettype none
// ==========================================
// Shared constants for servo enable and mode selection
package sems_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_ACTIVE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SPEED1 = 8'h0C;
    localparam logic [7:0] OFS_SPEED2 = 8'h10;
    localparam logic [7:0] OFS_SPEED3 = 8'h14;
    localparam logic [7:0] OFS_PULSES = 8'h18;
    // Config and active word field positions
    localparam int POS_METHOD = 0;
    localparam int POS_SRC = 4;
    localparam int POS_TERM = 8;
    // Status word field positions
    localparam int POS_POWERED = 0;
    localparam int POS_READY = 1;
    localparam int POS_EXCITE = 2;
    localparam int POS_ENABLE = 3;
    localparam int POS_LOOP = 4;
    // Reset values
    localparam logic [3:0] RST_METHOD = 4'h0;
    localparam logic RST_SRC = 1'b0;
    localparam logic [2:0] RST_TERM = 3'h0;
    localparam logic [15:0] RST_SPEED = 16'h0000;
    // Control method codes
    localparam logic [3:0] M_SPEED = 4'h0;
    localparam logic [3:0] M_POS = 4'h1;
    localparam logic [3:0] M_TORQUE = 4'h2;
    localparam logic [3:0] M_PRESET = 4'h3;
    localparam logic [3:0] M_SW_FIRST = 4'h4;
    localparam logic [3:0] M_SW_LAST = 4'hE;
    // Enable source codes
    localparam logic SRC_PIN = 1'b0;
    localparam logic SRC_AUTO = 1'b1;
    // One-hot loop selections
    localparam logic [3:0] LOOP_SPEED = 4'h1;
    localparam logic [3:0] LOOP_POS = 4'h2;
    localparam logic [3:0] LOOP_TORQUE = 4'h4;
    localparam logic [3:0] LOOP_PRESET = 4'h8;
    // Power sequencing states
    typedef enum logic [0:0] {
        PWR_OFF = 1'b0,
        PWR_ON = 1'b1
    } sems_pwr_t;
endpackage : sems_pkg
`default_nettype wire

// ===== sems_sync.sv
`default_nettype none
// ==========================================
// Two-stage synchroniser for pin inputs
module sems_sync #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync_out <= '0;
        end else if (pce) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sems_sync
`default_nettype wire

// ===== sems_mode_dec.sv
`default_nettype none
// ==========================================
// Control method decode to a one-hot loop choice
module sems_mode_dec (
    input wire logic [3:0] method,
    input wire logic switch_active,
    output logic [3:0] loop_sel
);
    // Basic method code to one-hot loop
    function automatic logic [3:0] basic_loop(input logic [1:0] m);
        case (m)
            2'h0: basic_loop = sems_pkg::LOOP_SPEED;
            2'h1: basic_loop = sems_pkg::LOOP_POS;
            2'h2: basic_loop = sems_pkg::LOOP_TORQUE;
            default: basic_loop = sems_pkg::LOOP_PRESET;
        endcase
    endfunction : basic_loop

    // Pair of basic methods per switching code, {primary, secondary}
    function automatic logic [3:0] pair_of(input logic [3:0] code);
        case (code)
            4'h4, 4'hA: pair_of = 4'hC;
            4'h5, 4'hB: pair_of = 4'hD;
            4'h6, 4'hC: pair_of = 4'hE;
            4'h7, 4'hD: pair_of = 4'h4;
            4'h8, 4'hE: pair_of = 4'h6;
            default: pair_of = 4'h8;
        endcase
    endfunction : pair_of

    logic [3:0] pair;

    // Basic codes map directly; switching codes alternate on the switch contact
    always_comb begin
        pair = pair_of(method);
        if (method <= sems_pkg::M_PRESET) begin
            loop_sel = basic_loop(method[1:0]);
        end else if (method <= sems_pkg::M_SW_LAST) begin
            loop_sel = switch_active ? basic_loop(pair[1:0]) : basic_loop(pair[3:2]);
        end else begin
            loop_sel = sems_pkg::LOOP_SPEED; // Reserved code falls back to analog speed
        end
    end
endmodule : sems_mode_dec
`default_nettype wire

// ===== sems_top.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`default_nettype none
// ==========================================
// Servo enable gating and control method selection
module sems_top #(
    parameter int TERMS = 8,
    parameter int TERM_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TERMS-1:0] input_terms,
    input wire logic main_power_ok,
    input wire logic control_power_ok,
    input wire logic ref_pulse,
    input wire logic proportional_select_n,
    input wire logic forward_limit_select_n,
    input wire logic reverse_limit_select_n,
    input wire logic drive_fault,
    output logic servo_ready,
    output logic motor_excite,
    output logic ref_accept,
    output logic [3:0] loop_select,
    output logic [15:0] preset_speed
);
    // ==========================================
    // State
    typedef struct packed {
        logic [3:0] cfg_method;
        logic cfg_src;
        logic [2:0] cfg_term;
        logic [3:0] act_method;
        logic act_src;
        logic [2:0] act_term;
        sems_pkg::sems_pwr_t pwr;
        logic ready;
        logic excite;
        logic accept;
        logic [3:0] loop_sel;
        logic [15:0] preset;
        logic [15:0] speed1;
        logic [15:0] speed2;
        logic [15:0] speed3;
        logic [31:0] pulses;
        logic pulse_q;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sems_state_t;

    sems_state_t st;
    sems_state_t next_st;

    // ==========================================
    // Pin synchronisers
    localparam int SYNC_W = TERMS + 6;
    logic [SYNC_W-1:0] sync_q;
    logic [TERMS-1:0] terms_s;
    logic main_pwr_s;
    logic ctrl_pwr_s;
    logic pulse_s;
    logic prop_n_s;
    logic fwd_n_s;
    logic rev_n_s;

    sems_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .async_in({reverse_limit_select_n, forward_limit_select_n, proportional_select_n,
                   ref_pulse, control_power_ok, main_power_ok, input_terms}),
        .sync_out(sync_q)
    );

    // Unpack the synchronised pins
    assign terms_s = sync_q[TERMS-1:0];
    assign main_pwr_s = sync_q[TERMS];
    assign ctrl_pwr_s = sync_q[TERMS+1];
    assign pulse_s = sync_q[TERMS+2];
    assign prop_n_s = sync_q[TERMS+3];
    assign fwd_n_s = sync_q[TERMS+4];
    assign rev_n_s = sync_q[TERMS+5];

    // ==========================================
    // Method decode
    logic [3:0] dec_loop;

    // Proportional contact doubles as the switch in switching modes
    sems_mode_dec u_dec (
        .method(st.act_method),
        .switch_active(~prop_n_s),
        .loop_sel(dec_loop)
    );

    // ==========================================
    // Combinational helpers
    logic enable_pin_n;
    logic both_on;
    logic both_off;
    logic pulse_edge;
    logic apb_setup;
    logic apb_write;
    logic [15:0] contact_speed;

    // Enable terminal picked by the applied selection
    assign enable_pin_n = terms_s[st.act_term[TERM_W-1:0]];
    assign both_on = main_pwr_s & ctrl_pwr_s;
    assign both_off = ~main_pwr_s & ~ctrl_pwr_s;
    assign pulse_edge = pulse_s & ~st.pulse_q;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & st.pready & pwrite;

    // Contact priority; no contact closed means zero speed
    always_comb begin
        if (!prop_n_s) begin
            contact_speed = st.speed1;
        end else if (!fwd_n_s) begin
            contact_speed = st.speed2;
        end else if (!rev_n_s) begin
            contact_speed = st.speed3;
        end else begin
            contact_speed = sems_pkg::RST_SPEED;
        end
    end

    // Address decode used only for error answers; reads decode in their own case
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            sems_pkg::OFS_CONFIG, sems_pkg::OFS_ACTIVE, sems_pkg::OFS_STATUS,
            sems_pkg::OFS_SPEED1, sems_pkg::OFS_SPEED2, sems_pkg::OFS_SPEED3,
            sems_pkg::OFS_PULSES: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic is_writable(input logic [7:0] a);
        case (a)
            sems_pkg::OFS_CONFIG, sems_pkg::OFS_SPEED1, sems_pkg::OFS_SPEED2,
            sems_pkg::OFS_SPEED3: is_writable = 1'b1;
            default: is_writable = 1'b0;
        endcase
    endfunction : is_writable

    // ==========================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.pulse_q = pulse_s;

        // Config only lands when power returns, so a live drive never changes mode
        case (st.pwr)
            sems_pkg::PWR_OFF: begin
                if (both_on) begin
                    next_st.pwr = sems_pkg::PWR_ON;
                    next_st.act_method = st.cfg_method;
                    next_st.act_src = st.cfg_src;
                    next_st.act_term = st.cfg_term;
                end
            end
            sems_pkg::PWR_ON: begin
                if (both_off) begin
                    next_st.pwr = sems_pkg::PWR_OFF;
                end
            end
            default: next_st.pwr = sems_pkg::PWR_OFF;
        endcase

        // Ready needs the drive powered and free of faults
        next_st.ready = (st.pwr == sems_pkg::PWR_ON) & ~drive_fault;

        // Excitation gated by ready and the chosen enable source
        if (!st.ready) begin
            next_st.excite = 1'b0;
        end else if (st.act_src == sems_pkg::SRC_AUTO) begin
            next_st.excite = 1'b1;
        end else begin
            next_st.excite = ~enable_pin_n;
        end

        // References accepted only while excited; host enables first
        next_st.accept = next_st.excite;

        // Loop choice, pulse counting and preset speed
        next_st.loop_sel = dec_loop;
        if (st.excite && st.loop_sel == sems_pkg::LOOP_POS && pulse_edge) begin
            next_st.pulses = st.pulses + 32'h0000_0001;
        end
        next_st.preset = (dec_loop == sems_pkg::LOOP_PRESET) ? contact_speed : sems_pkg::RST_SPEED;

        // APB: answer lands one cycle after setup, no wait states
        next_st.pready = apb_setup;
        next_st.pslverr = 1'b0;
        if (apb_setup) begin
            next_st.pslverr = ~is_mapped(paddr) | (pwrite & ~is_writable(paddr));
            next_st.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    sems_pkg::OFS_CONFIG: begin
                        next_st.prdata[sems_pkg::POS_METHOD +: 4] = st.cfg_method;
                        next_st.prdata[sems_pkg::POS_SRC] = st.cfg_src;
                        next_st.prdata[sems_pkg::POS_TERM +: 3] = st.cfg_term;
                    end
                    sems_pkg::OFS_ACTIVE: begin
                        next_st.prdata[sems_pkg::POS_METHOD +: 4] = st.act_method;
                        next_st.prdata[sems_pkg::POS_SRC] = st.act_src;
                        next_st.prdata[sems_pkg::POS_TERM +: 3] = st.act_term;
                    end
                    sems_pkg::OFS_STATUS: begin
                        next_st.prdata[sems_pkg::POS_POWERED] = (st.pwr == sems_pkg::PWR_ON);
                        next_st.prdata[sems_pkg::POS_READY] = st.ready;
                        next_st.prdata[sems_pkg::POS_EXCITE] = st.excite;
                        next_st.prdata[sems_pkg::POS_ENABLE] = ~enable_pin_n;
                        next_st.prdata[sems_pkg::POS_LOOP +: 4] = st.loop_sel;
                    end
                    sems_pkg::OFS_SPEED1: next_st.prdata[15:0] = st.speed1;
                    sems_pkg::OFS_SPEED2: next_st.prdata[15:0] = st.speed2;
                    sems_pkg::OFS_SPEED3: next_st.prdata[15:0] = st.speed3;
                    sems_pkg::OFS_PULSES: next_st.prdata = st.pulses;
                    default: next_st.prdata = 32'h0000_0000;
                endcase
            end
        end
        if (!psel) begin
            next_st.pready = 1'b0;
        end

        // Writes take effect at the completing edge only
        if (apb_write) begin
            case (paddr)
                sems_pkg::OFS_CONFIG: begin
                    next_st.cfg_method = pwdata[sems_pkg::POS_METHOD +: 4];
                    next_st.cfg_src = pwdata[sems_pkg::POS_SRC];
                    next_st.cfg_term = pwdata[sems_pkg::POS_TERM +: 3];
                end
                sems_pkg::OFS_SPEED1: next_st.speed1 = pwdata[15:0];
                sems_pkg::OFS_SPEED2: next_st.speed2 = pwdata[15:0];
                sems_pkg::OFS_SPEED3: next_st.speed3 = pwdata[15:0];
                default: next_st.pulses = st.pulses;
            endcase
        end
    end

    // ==========================================
    // Registers, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg_method <= sems_pkg::RST_METHOD;
            st.cfg_src <= sems_pkg::RST_SRC;
            st.cfg_term <= sems_pkg::RST_TERM;
            st.act_method <= sems_pkg::RST_METHOD;
            st.act_src <= sems_pkg::RST_SRC;
            st.act_term <= sems_pkg::RST_TERM;
            st.pwr <= sems_pkg::PWR_OFF;
            st.loop_sel <= sems_pkg::LOOP_SPEED;
        end else if (pce) begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign servo_ready = st.ready;
    assign motor_excite = st.excite;
    assign ref_accept = st.accept;
    assign loop_select = st.loop_sel;
    assign preset_speed = st.preset;

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Method selection, pulse counting and preset speed
    chk_speed_analog: assert property (pce && st.act_method == sems_pkg::M_SPEED |=>
        st.loop_sel == sems_pkg::LOOP_SPEED) else $error("analog speed loop not selected");
    chk_pos_select: assert property (pce && st.act_method == sems_pkg::M_POS |=>
        st.loop_sel == sems_pkg::LOOP_POS) else $error("position loop not selected");
    chk_pulse_count: assert property (pce && st.excite && st.loop_sel == sems_pkg::LOOP_POS && pulse_edge
        |=> st.pulses == $past(st.pulses) + 32'h0000_0001) else $error("reference pulse not counted");
    chk_torque_select: assert property (pce && st.act_method == sems_pkg::M_TORQUE |=>
        st.loop_sel == sems_pkg::LOOP_TORQUE) else $error("torque loop not selected");
    chk_preset_zero: assert property (pce && st.act_method == sems_pkg::M_PRESET && prop_n_s && fwd_n_s
        && rev_n_s |=> st.preset == 16'h0000) else $error("preset speed not zero without contacts");
    chk_switch_onehot: assert property (pce && st.act_method >= sems_pkg::M_SW_FIRST
        && st.act_method <= sems_pkg::M_SW_LAST |=> $onehot(st.loop_sel)) else $error("switching mode choice bad");

    // Enable gating and power-cycle apply
    chk_enable_on: assert property (pce && st.ready && st.act_src == sems_pkg::SRC_PIN && !enable_pin_n
        |=> st.excite && st.accept) else $error("motor not energised with enable low");
    chk_enable_off: assert property (pce && st.act_src == sems_pkg::SRC_PIN && enable_pin_n
        |=> !st.excite && !st.accept) else $error("motor energised with enable high");
    chk_auto_enable: assert property (pce && st.ready && st.act_src == sems_pkg::SRC_AUTO
        |=> st.excite) else $error("auto excitation missing after ready");
    chk_apply_cycle: assert property (pce && st.pwr == sems_pkg::PWR_ON |=>
        $stable(st.act_src) && $stable(st.act_method) && $stable(st.act_term)) else $error("config applied while on");
    chk_power_apply: assert property (pce && st.pwr == sems_pkg::PWR_OFF && both_on |=>
        st.act_method == $past(st.cfg_method) && st.act_src == $past(st.cfg_src)
        && st.act_term == $past(st.cfg_term)) else $error("config not applied at power up");
    // Excitation never runs ahead of ready, whatever the source
    chk_excite_ready: assert property (pce && !st.ready |=> !st.excite)
        else $error("excitation without ready");
    chk_pin_source: assert property (pce && st.ready && st.act_src == sems_pkg::SRC_PIN |=>
        st.excite == !$past(enable_pin_n)) else $error("enable input not honoured");

    // Bus answer; no wait states, so one cycle after setup
    chk_apb_answer: assert property (pce && psel && !penable |=> pce |-> st.pready)
        else $error("apb answer late");

    // Main scenarios reached
    cov_auto_excite: cover property (st.act_src == sems_pkg::SRC_AUTO ##1 st.excite);
    cov_pin_excite: cover property (!st.excite ##1 st.excite && st.act_src == sems_pkg::SRC_PIN);
    cov_power_cycle: cover property (st.pwr == sems_pkg::PWR_OFF ##1 st.pwr == sems_pkg::PWR_ON);
    cov_pulse: cover property (st.pulses != 32'h0000_0000);
    cov_switch_mode: cover property (st.act_method >= sems_pkg::M_SW_FIRST && st.loop_sel == sems_pkg::LOOP_SPEED);
endmodule : sems_top
`default_nettype wire

// ===== sems_host_model.sv
`default_nettype none
// ==========================================
// Host controller: drives the enable terminal and reference pulses
module sems_host_model (
    input wire logic pclk,
    input wire logic en_on,
    input wire logic [2:0] term,
    input wire logic [7:0] n_pulses,
    input wire logic go,
    output logic [7:0] input_terms,
    output logic ref_pulse,
    output logic busy
);
    logic [9:0] left = 10'h000;

    // Only the chosen terminal carries the active-low enable; the rest idle high
    always_comb begin
        input_terms = 8'hFF;
        input_terms[term] = ~en_on;
    end

    // Four cycles a pulse; a burst starts only once enabled, never before
    always_ff @(posedge pclk) begin
        if (go && en_on && left == 10'h000) begin
            left <= {n_pulses, 2'b00};
        end else if (left != 10'h000) begin
            left <= left - 10'h001;
        end
    end

    // Bit 1 of the down count gives one high pair per pulse
    assign ref_pulse = left[1];
    assign busy = (left != 10'h000);
endmodule : sems_host_model
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
// ==========================================
// Directed bench for enable gating and method selection
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ref_pulse, busy, servo_ready, motor_excite, ref_accept;
    logic [7:0] input_terms;
    logic main_ok = 1'b0, ctl_ok = 1'b0, fault = 1'b0, en_on = 1'b0, go = 1'b0;
    logic prop_n = 1'b1, fwd_n = 1'b1, rev_n = 1'b1;
    logic [2:0] term = 3'h0;
    logic [7:0] n_pulses = 8'h05;
    logic [3:0] loop_select;
    logic [15:0] preset_speed;
    int errors = 0;
    int n_tests = 0;

    // Clock at 125 MHz
    always #4 pclk = ~pclk;

    sems_top u_sems_top (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_terms(input_terms), .main_power_ok(main_ok), .control_power_ok(ctl_ok), .ref_pulse(ref_pulse),
        .proportional_select_n(prop_n), .forward_limit_select_n(fwd_n), .reverse_limit_select_n(rev_n),
        .drive_fault(fault), .servo_ready(servo_ready), .motor_excite(motor_excite), .ref_accept(ref_accept),
        .loop_select(loop_select), .preset_speed(preset_speed));
    sems_host_model u_sems_host_model (.pclk(pclk), .en_on(en_on), .term(term), .n_pulses(n_pulses),
        .go(go), .input_terms(input_terms), .ref_pulse(ref_pulse), .busy(busy));

    // ==========================================
    // Shared tasks
    task automatic tally_and_finish;
        $display("errors=%0d tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask : settle

    // Both supplies off then on, so a new setting is taken
    task automatic power_cycle;
        @(posedge pclk);
        main_ok <= 1'b0;
        ctl_ok <= 1'b0;
        settle();
        main_ok <= 1'b1;
        ctl_ok <= 1'b1;
        settle();
    endtask : power_cycle

    task automatic setup(input logic [3:0] m, input logic s, input logic [2:0] t);
        apb(1'b1, sems_pkg::OFS_CONFIG, {21'h0, t, 3'h0, s, m});
        power_cycle();
    endtask : setup

    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk(loop_select, sems_pkg::LOOP_SPEED);
        chk(motor_excite, 1'b0);
        apb(1'b0, sems_pkg::OFS_CONFIG, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    task automatic t_bus;
        apb(1'b0, 8'h1C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, sems_pkg::OFS_ACTIVE, 32'h3);
        chk(err, 1'b1);
    endtask : t_bus

    task automatic t_methods;
        logic [3:0] exp_loop [4] = '{sems_pkg::LOOP_SPEED, sems_pkg::LOOP_POS, sems_pkg::LOOP_TORQUE,
            sems_pkg::LOOP_PRESET};
        for (int m = 0; m < 4; m++) begin
            setup(m[3:0], 1'b0, 3'h0);
            chk(loop_select, exp_loop[m]);
            apb(1'b0, sems_pkg::OFS_ACTIVE, 32'h0);
            chk(rd, m);
        end
    endtask : t_methods

    // Open contact picks the primary loop, closed the secondary
    task automatic t_switch;
        setup(4'h4, 1'b0, 3'h0);
        chk(loop_select, sems_pkg::LOOP_PRESET);
        prop_n <= 1'b0;
        settle();
        chk(loop_select, sems_pkg::LOOP_SPEED);
        setup(4'h8, 1'b0, 3'h0);
        chk(loop_select, sems_pkg::LOOP_TORQUE);
        prop_n <= 1'b1;
        settle();
        chk(loop_select, sems_pkg::LOOP_POS);
        setup(4'hD, 1'b0, 3'h0);
        chk(loop_select, sems_pkg::LOOP_POS);
        setup(4'hF, 1'b0, 3'h0);
        chk(loop_select, sems_pkg::LOOP_SPEED);
    endtask : t_switch

    task automatic t_enable;
        setup(4'h0, 1'b0, 3'h0);
        chk({servo_ready, motor_excite}, 2'b10);
        en_on <= 1'b1;
        settle();
        chk({motor_excite, ref_accept}, 2'b11);
        en_on <= 1'b0;
        settle();
        chk({motor_excite, ref_accept}, 2'b00);
    endtask : t_enable

    // Enable moved to terminal 5; terminal 0 no longer counts
    task automatic t_term;
        setup(4'h0, 1'b0, 3'h5);
        en_on <= 1'b1;
        settle();
        chk(motor_excite, 1'b0);
        term <= 3'h5;
        settle();
        chk(motor_excite, 1'b1);
        en_on <= 1'b0;
        term <= 3'h0;
    endtask : t_term

    task automatic t_pulses;
        logic [31:0] p0;
        setup(4'h1, 1'b0, 3'h0);
        en_on <= 1'b1;
        settle();
        apb(1'b0, sems_pkg::OFS_PULSES, 32'h0);
        p0 = rd;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        // The model's count lands on this edge; look one edge later
        @(posedge pclk);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge pclk);
        if (busy !== 1'b0) begin
            errors++;
            tally_and_finish();
        end
        settle();
        apb(1'b0, sems_pkg::OFS_PULSES, 32'h0);
        chk(rd, p0 + 32'd5);
    endtask : t_pulses

    // Each contact alone picks its stored speed; none gives zero
    task automatic t_preset;
        for (int k = 1; k < 4; k++) apb(1'b1, 8'h08 + 8'(4 * k), 32'h111 * k);
        setup(4'h3, 1'b0, 3'h0);
        for (int k = 0; k < 4; k++) begin
            {prop_n, fwd_n, rev_n} <= ~(3'b100 >> k);
            settle();
            chk(preset_speed, k < 3 ? 16'h0111 * (k + 1) : 16'h0000);
        end
        en_on <= 1'b0;
    endtask : t_preset

    task automatic t_auto;
        setup(4'h0, 1'b0, 3'h0);
        apb(1'b1, sems_pkg::OFS_CONFIG, 32'h10);
        settle();
        apb(1'b0, sems_pkg::OFS_ACTIVE, 32'h0);
        chk({rd[30:0], motor_excite}, 32'h0);
        power_cycle();
        chk(motor_excite, 1'b1);
        fault <= 1'b1;
        settle();
        chk(motor_excite, 1'b0);
        fault <= 1'b0;
    endtask : t_auto

    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_bus();
        t_methods();
        t_switch();
        t_enable();
        t_term();
        t_pulses();
        t_preset();
        t_auto();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
